// [common/aim_pkg.sv]
/*
 * Package for the audio input mixer gain register bank: register offsets,
 * field positions, reset values and decode constants.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package aim_pkg;

    // Printed register indices; byte address is four times the index
    localparam logic [7:0]  AIM_IDX_MIC_CFG   = 8'h0B;
    localparam logic [7:0]  AIM_IDX_BIAS_CFG  = 8'h0C;
    localparam logic [7:0]  AIM_IDX_MON_ATTEN = 8'h0D;
    localparam logic [7:0]  AIM_IDX_PHONE_IN  = 8'h0E;
    localparam logic [7:0]  AIM_IDX_AUX_L     = 8'h0F;
    localparam logic [7:0]  AIM_IDX_AUX_R     = 8'h10;
    localparam logic [7:0]  AIM_IDX_DAC       = 8'h11;
    localparam int          AIM_NUM_REGS      = 7;
    localparam logic [7:0]  AIM_REG_RESET     = 8'h00;

    // Microphone configuration fields
    localparam int AIM_MIC_GAIN_LSB  = 0;
    localparam int AIM_MIC_MUTE_BIT  = 4;
    localparam int AIM_MIC_SE_BIT    = 5;
    localparam int AIM_MIC_EXT_BIT   = 6;
    localparam logic [7:0] AIM_MIC_MASK = 8'h7F;

    // Bias and button fields
    localparam int AIM_VG_BIT        = 0;
    localparam int AIM_BIAS_LSB      = 1;
    localparam int AIM_BTN_SER_BIT   = 3;
    localparam int AIM_DBNC_LSB      = 4;
    localparam logic [7:0] AIM_BIAS_MASK = 8'h3F;

    // Monitor feed attenuation
    localparam logic [7:0] AIM_MON_MASK    = 8'h0F;
    localparam logic [3:0] AIM_MON_MAX_CODE = 4'hA;

    // Phone line input
    localparam int AIM_PL_MUTE_BIT   = 5;
    localparam logic [7:0] AIM_PL_MASK = 8'h3F;

    // Auxiliary and DAC fields
    localparam int AIM_AUX_BOOST_BIT = 5;
    localparam int AIM_AUX_MUTE_BIT  = 6;
    localparam int AIM_AUX_SRC_BIT   = 7;
    localparam int AIM_DAC_USEAUX_BIT = 5;
    localparam int AIM_DAC_BOOST_BIT = 6;
    localparam int AIM_DAC_MUTE_BIT  = 7;
    localparam logic [7:0] AIM_FULL_MASK = 8'hFF;

    // Debounce times in ms per code and the clock rate
    localparam int AIM_CLK_HZ        = 25_000_000;
    localparam int AIM_DBNC_MS_0     = 0;
    localparam int AIM_DBNC_MS_1     = 8;
    localparam int AIM_DBNC_MS_2     = 16;
    localparam int AIM_DBNC_MS_3     = 32;
    localparam int AIM_CYC_PER_MS    = AIM_CLK_HZ / 1000;

    // Level codes in half-dB units; gains are signed tenths avoided
    localparam int AIM_LVL_W         = 5;
    localparam int AIM_DB_W          = 9;

    // AHB constants
    localparam logic [1:0] AIM_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] AIM_HTRANS_SEQ    = 2'h3;

endpackage

// [verilog/aim_regs.sv]
/*
 * Register bank for the microphone preamp, bias, monitor feed, phone-line,
 * auxiliary and playback mixer levels, with an AHB-Lite slave front end.
 * Assumes one 25 MHz clock, an async active-high reset, and analog cells
 * that take the decoded control outputs below.
 */
`timescale 1ns/1ps
//
// Overview of operation
// RULE1: 4-bit preamp gain, 6 dB plus 2 dB/step
// RULE2: Bit 4 mutes the microphone preamp
// RULE3: Bit 5 makes internal mic single-ended
// RULE4: Bit 6 selects external mic, else internal
// RULE5: Controller waits 300 ms after mic switch
// RULE6: Bit 0 selects virtual ground 1.2/1.5V
// RULE7: Bias field; only selected bias output driven
// RULE8: Bit 3 selects series button, else parallel
// RULE9: Parallel button debounce 0/8/16/32 ms
// RULE10: Monitor feed cut, -30 dB plus 3 dB/step
// RULE11: Controller holds monitor cut at zero settling
// RULE12: Controller deselects mic while DC settles
// RULE13: Phone-line gain -34.5 dB plus 1.5 dB/step
// RULE14: Bit 5 mutes phone-line input at source
// RULE15: Aux levels 1.5 dB steps, boost shifts range
// RULE16: Aux bit 5 boosts gain by 12 dB
// RULE17: Aux bit 6 mutes that aux input
// RULE18: Aux bit 7 picks aux, else DAC, source
// RULE19: DAC level field, same steps as aux
// RULE20: DAC bit 5 borrows aux level registers
// RULE21: DAC bit 6 boosts DAC by 12 dB
// RULE22: DAC mute waits for next zero crossing
// RULE23: 8-bit registers read back, undefined bits zero
//
module aim_regs
    import aim_pkg::*;
#(
    parameter int DBNC_MS_SCALE = AIM_CYC_PER_MS
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Analog status pins
    input  wire logic        agc_enable_in,
    input  wire logic        dac_zero_cross_in,
    input  wire logic        button_raw_in,
    // Decoded analog controls
    output logic      [3:0]  preamp_gain_code_out,
    output logic             preamp_mute_out,
    output logic             internal_mic_single_ended_out,
    output logic             external_mic_select_out,
    output logic             ext_mic_neg_ground_out,
    output logic             capless_virtual_ground_sel_out,
    output logic      [1:0]  bias_code_out,
    output logic             outer_mic_supply_en_out,
    output logic             inner_mic_supply_en_out,
    output logic             button_series_out,
    output logic             button_pressed_out,
    output logic      [3:0]  monitor_feed_cut_out,
    output logic      [4:0]  phone_line_in_gain_out,
    output logic             phone_line_in_silence_out,
    output logic      [4:0]  aux_l_level_out,
    output logic      [4:0]  aux_r_level_out,
    output logic             aux_l_boost_out,
    output logic             aux_r_boost_out,
    output logic             aux_l_mute_out,
    output logic             aux_r_mute_out,
    output logic             mixer_l_from_aux_out,
    output logic             mixer_r_from_aux_out,
    output logic      [4:0]  dac_l_level_out,
    output logic      [4:0]  dac_r_level_out,
    output logic             dac_boost_out,
    output logic             dac_mute_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [AIM_NUM_REGS-1:0][7:0] regs;
        logic                         dp_wr;
        logic [2:0]                   dp_idx;
        logic                         dp_hit;
        logic [31:0]                  rdata;
        logic [1:0]                   btn_sync;
        logic                         btn_stable;
        logic [20:0]                  dbnc_cnt;
        logic                         dac_mute;
        logic                         pre_mute;
        logic [3:0]                   pre_gain;
        logic [1:0]                   ext_sync;
    } aim_state_t;

    aim_state_t st_q;
    aim_state_t st_d;

    ////////////////////////////////////////////////////////////////////////////
    // Decode a word address into a slot; 7 means unmapped
    function automatic logic [2:0] slot_of(input logic [31:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[31:10] != 22'h0) begin
            slot_of = 3'h7;
        end else begin
            case (idx)
                AIM_IDX_MIC_CFG:   slot_of = 3'h0;
                AIM_IDX_BIAS_CFG:  slot_of = 3'h1;
                AIM_IDX_MON_ATTEN: slot_of = 3'h2;
                AIM_IDX_PHONE_IN:  slot_of = 3'h3;
                AIM_IDX_AUX_L:     slot_of = 3'h4;
                AIM_IDX_AUX_R:     slot_of = 3'h5;
                AIM_IDX_DAC:       slot_of = 3'h6;
                default:           slot_of = 3'h7;
            endcase
        end
    endfunction

    // Writable bits per slot; others read back as zero
    function automatic logic [7:0] mask_of(input logic [2:0] s);
        case (s)
            3'h0:    mask_of = AIM_MIC_MASK;
            3'h1:    mask_of = AIM_BIAS_MASK;
            3'h2:    mask_of = AIM_MON_MASK;
            3'h3:    mask_of = AIM_PL_MASK;
            3'h4,
            3'h5,
            3'h6:    mask_of = AIM_FULL_MASK;
            default: mask_of = 8'h00;
        endcase
    endfunction

    // Debounce length in cycles for a 2-bit code
    function automatic logic [20:0] dbnc_cycles(input logic [1:0] code);
        int ms;
        case (code)
            2'h0:    ms = AIM_DBNC_MS_0;
            2'h1:    ms = AIM_DBNC_MS_1;
            2'h2:    ms = AIM_DBNC_MS_2;
            default: ms = AIM_DBNC_MS_3;
        endcase
        dbnc_cycles = 21'(ms * DBNC_MS_SCALE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic       addr_phase;
    logic [2:0] a_slot;
    logic [7:0] mic_r;
    logic [7:0] bias_r;
    logic [7:0] dac_r;
    logic [20:0] dbnc_len;

    always_comb begin
        st_d       = st_q;
        addr_phase = hsel_in && hready_in && htrans_in[1];
        a_slot     = slot_of(haddr_in);
        mic_r      = st_q.regs[0];
        bias_r     = st_q.regs[1];
        dac_r      = st_q.regs[6];
        dbnc_len   = dbnc_cycles(bias_r[AIM_DBNC_LSB +: 2]);

        // Data phase of a write stores only defined bits [RULE23]
        if (st_q.dp_wr && st_q.dp_hit) begin
            st_d.regs[st_q.dp_idx] = hwdata_in[7:0] & mask_of(st_q.dp_idx);
        end

        // Address phase: latch, and prepare read data one cycle early
        st_d.dp_wr  = addr_phase && hwrite_in;
        st_d.dp_idx = a_slot;
        st_d.dp_hit = addr_phase && (a_slot != 3'h7);
        if (addr_phase && !hwrite_in && a_slot != 3'h7) begin
            st_d.rdata = {24'h0, st_q.regs[a_slot]}; // [RULE23]
        end else begin
            st_d.rdata = 32'h0;
        end

        // Preamp gain follows the register only while AGC is off [RULE1]
        if (!agc_enable_in) begin
            st_d.pre_gain = mic_r[AIM_MIC_GAIN_LSB +: 4];
        end
        st_d.pre_mute = mic_r[AIM_MIC_MUTE_BIT]; // [RULE2]

        // DAC mute engages only at a zero crossing; unmute is immediate [RULE22]
        st_d.ext_sync = {st_q.ext_sync[0], dac_zero_cross_in};
        if (!dac_r[AIM_DAC_MUTE_BIT]) begin
            st_d.dac_mute = 1'b0;
        end else if (st_q.ext_sync[1]) begin
            st_d.dac_mute = 1'b1;
        end

        // Parallel button debounce; series button passes undelayed [RULE8] [RULE9]
        st_d.btn_sync = {st_q.btn_sync[0], button_raw_in};
        if (st_q.btn_sync[1] == st_q.btn_stable) begin
            st_d.dbnc_cnt = 21'h0;
        end else if (bias_r[AIM_BTN_SER_BIT] || st_q.dbnc_cnt >= dbnc_len) begin
            st_d.btn_stable = st_q.btn_sync[1];
            st_d.dbnc_cnt   = 21'h0;
        end else begin
            st_d.dbnc_cnt = st_q.dbnc_cnt + 21'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; registers reset to zero, defaults internal mic, DAC feed

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, from flip-flops or constants, some through an inverter or a mux

    logic [7:0] aux_l_r;
    logic [7:0] aux_r_r;
    logic [7:0] mon_r;
    logic [7:0] pl_r;

    assign aux_l_r = st_q.regs[4];
    assign aux_r_r = st_q.regs[5];
    assign mon_r   = st_q.regs[2];
    assign pl_r    = st_q.regs[3];

    // Bus answers with zero wait states and always OKAY
    assign hrdata_out    = st_q.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    assign preamp_gain_code_out          = st_q.pre_gain;                     // [RULE1]
    assign preamp_mute_out               = st_q.pre_mute;                     // [RULE2]
    assign internal_mic_single_ended_out = st_q.regs[0][AIM_MIC_SE_BIT];      // [RULE3]
    assign external_mic_select_out       = st_q.regs[0][AIM_MIC_EXT_BIT];     // [RULE4]
    assign ext_mic_neg_ground_out        = st_q.regs[0][AIM_MIC_EXT_BIT];     // [RULE4]
    assign capless_virtual_ground_sel_out = st_q.regs[1][AIM_VG_BIT];         // [RULE6]
    assign bias_code_out                 = st_q.regs[1][AIM_BIAS_LSB +: 2];   // [RULE7]
    // Only one bias pin is driven, chosen by the mic select [RULE7]
    assign outer_mic_supply_en_out       = st_q.regs[0][AIM_MIC_EXT_BIT];
    assign inner_mic_supply_en_out       = ~st_q.regs[0][AIM_MIC_EXT_BIT];
    assign button_series_out             = st_q.regs[1][AIM_BTN_SER_BIT];     // [RULE8]
    assign button_pressed_out            = st_q.btn_stable;                   // [RULE9]
    // Codes above 1010 are saturated to 0 dB by the cell [RULE10]
    assign monitor_feed_cut_out          = mon_r[3:0];
    assign phone_line_in_gain_out        = pl_r[4:0];                         // [RULE13]
    assign phone_line_in_silence_out     = pl_r[AIM_PL_MUTE_BIT];             // [RULE14]
    assign aux_l_level_out               = aux_l_r[4:0];                      // [RULE15]
    assign aux_r_level_out               = aux_r_r[4:0];                      // [RULE15]
    assign aux_l_boost_out               = aux_l_r[AIM_AUX_BOOST_BIT];        // [RULE16]
    assign aux_r_boost_out               = aux_r_r[AIM_AUX_BOOST_BIT];        // [RULE16]
    assign aux_l_mute_out                = aux_l_r[AIM_AUX_MUTE_BIT];         // [RULE17]
    assign aux_r_mute_out                = aux_r_r[AIM_AUX_MUTE_BIT];         // [RULE17]
    assign mixer_l_from_aux_out          = aux_l_r[AIM_AUX_SRC_BIT];          // [RULE18]
    assign mixer_r_from_aux_out          = aux_r_r[AIM_AUX_SRC_BIT];          // [RULE18]
    // Balance mode borrows the aux level fields for the DAC [RULE19] [RULE20]
    assign dac_l_level_out = st_q.regs[6][AIM_DAC_USEAUX_BIT] ? aux_l_r[4:0]
        : st_q.regs[6][4:0];
    assign dac_r_level_out = st_q.regs[6][AIM_DAC_USEAUX_BIT] ? aux_r_r[4:0]
        : st_q.regs[6][4:0];
    assign dac_boost_out                 = st_q.regs[6][AIM_DAC_BOOST_BIT];   // [RULE21]
    assign dac_mute_out                  = st_q.dac_mute;                     // [RULE22]

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_wr_addr;
        hsel_in && hready_in && htrans_in[1] && hwrite_in &&
            (slot_of(haddr_in) != 3'h7);
    endsequence

    sequence s_rd_addr;
        hsel_in && hready_in && htrans_in[1] && !hwrite_in &&
            (slot_of(haddr_in) != 3'h7);
    endsequence

    property p_wr_store;
        logic [2:0] s;
        @(posedge clk_in) disable iff (rst_in)
        (s_wr_addr, s = slot_of(haddr_in)) ##1 1'b1 |=>
            st_q.regs[s] == ($past(hwdata_in[7:0]) & mask_of(s));
    endproperty
    a_wr_store: assert property (p_wr_store) else $error("write not stored"); // [RULE23]

    property p_rd_back;
        logic [7:0] v;
        @(posedge clk_in) disable iff (rst_in)
        (s_rd_addr, v = st_q.regs[slot_of(haddr_in)]) |=>
            hrdata_out == {24'h0, v};
    endproperty
    a_rd_back: assert property (p_rd_back) else $error("read data wrong"); // [RULE23]

    property p_gain_agc;
        @(posedge clk_in) disable iff (rst_in)
        !agc_enable_in |=> preamp_gain_code_out == $past(st_q.regs[0][3:0]);
    endproperty
    a_gain_agc: assert property (p_gain_agc) else $error("preamp gain not followed"); // [RULE1]

    property p_gain_hold;
        @(posedge clk_in) disable iff (rst_in)
        agc_enable_in |=> $stable(preamp_gain_code_out);
    endproperty
    a_gain_hold: assert property (p_gain_hold) else $error("gain moved under AGC"); // [RULE1]

    property p_mute_mic;
        @(posedge clk_in) disable iff (rst_in)
        st_q.regs[0][AIM_MIC_MUTE_BIT] |=> preamp_mute_out;
    endproperty
    a_mute_mic: assert property (p_mute_mic) else $error("preamp not muted"); // [RULE2]

    property p_bias_one;
        @(posedge clk_in) disable iff (rst_in)
        outer_mic_supply_en_out != inner_mic_supply_en_out;
    endproperty
    a_bias_one: assert property (p_bias_one) else $error("two bias pins driven"); // [RULE7]

    property p_dac_mute_zc;
        @(posedge clk_in) disable iff (rst_in)
        $rose(dac_mute_out) |-> $past(st_q.ext_sync[1]) && $past(st_q.regs[6][AIM_DAC_MUTE_BIT]);
    endproperty
    a_dac_mute_zc: assert property (p_dac_mute_zc) else $error("DAC muted off crossing"); // [RULE22]

    property p_dac_balance;
        @(posedge clk_in) disable iff (rst_in)
        st_q.regs[6][AIM_DAC_USEAUX_BIT] |-> dac_l_level_out == st_q.regs[4][4:0] &&
                                              dac_r_level_out == st_q.regs[5][4:0];
    endproperty
    a_dac_balance: assert property (p_dac_balance) else $error("balance levels not used"); // [RULE20]

    property p_btn_series;
        @(posedge clk_in) disable iff (rst_in)
        button_series_out && (st_q.btn_sync[1] != button_pressed_out) |=>
            button_pressed_out == $past(st_q.btn_sync[1]);
    endproperty
    a_btn_series: assert property (p_btn_series) else $error("series button delayed"); // [RULE8]

    property p_btn_zero;
        @(posedge clk_in) disable iff (rst_in)
        !button_series_out && st_q.regs[1][5:4] == 2'h0 &&
            (st_q.btn_sync[1] != button_pressed_out) |=>
            button_pressed_out == $past(st_q.btn_sync[1]);
    endproperty
    a_btn_zero: assert property (p_btn_zero) else $error("zero debounce delayed"); // [RULE9]

    // Release of the mute never waits for a crossing
    property p_dac_unmute;
        @(posedge clk_in) disable iff (rst_in)
        !st_q.regs[6][AIM_DAC_MUTE_BIT] |=>
            !dac_mute_out;
    endproperty
    a_dac_unmute: assert property (p_dac_unmute) else $error("DAC mute held"); // [RULE22]

    property p_btn_wait;
        @(posedge clk_in) disable iff (rst_in)
        !button_series_out && st_q.regs[1][5:4] != 2'h0 && $changed(st_q.btn_sync[1]) |=>
            $stable(button_pressed_out);
    endproperty
    a_btn_wait: assert property (p_btn_wait) else $error("button not debounced"); // [RULE9]

endmodule

// [testbench/audio_input_mixer_gain_regs_test.sv]
/*
 * Self-checking bench for the audio input mixer gain register bank.
 * Assumes it alone drives every design input, just after rising edges.
 */
`timescale 1ns/1ps
module audio_input_mixer_gain_regs_test
    import aim_pkg::*;
;
    localparam int SCALE = 2;
    localparam int LIMIT = 20000;
    logic        clk_in, rst_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out;
    logic [1:0]  htrans_in, bias_code_out;
    logic [2:0]  hsize_in;
    logic        agc_enable_in, dac_zero_cross_in, button_raw_in;
    logic [3:0]  preamp_gain_code_out, monitor_feed_cut_out;
    logic        preamp_mute_out, internal_mic_single_ended_out, external_mic_select_out;
    logic        ext_mic_neg_ground_out, capless_virtual_ground_sel_out, outer_mic_supply_en_out;
    logic        inner_mic_supply_en_out, button_series_out, button_pressed_out, phone_line_in_silence_out;
    logic [4:0]  phone_line_in_gain_out, aux_l_level_out, aux_r_level_out, dac_l_level_out, dac_r_level_out;
    logic        aux_l_boost_out, aux_r_boost_out, aux_l_mute_out, aux_r_mute_out;
    logic        mixer_l_from_aux_out, mixer_r_from_aux_out, dac_boost_out, dac_mute_out;
    int          fail_count, comparisons, cycles, ms;
    logic [7:0]  idx_tab [7];
    logic [7:0]  msk_tab [7];

    // The one slave's ready is the bus ready
    assign hready_in = hreadyout_out;

    aim_regs #(.DBNC_MS_SCALE(SCALE)) u_aim_regs (
        .clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
        .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .agc_enable_in(agc_enable_in), .dac_zero_cross_in(dac_zero_cross_in),
        .button_raw_in(button_raw_in), .preamp_gain_code_out(preamp_gain_code_out),
        .preamp_mute_out(preamp_mute_out), .internal_mic_single_ended_out(internal_mic_single_ended_out),
        .external_mic_select_out(external_mic_select_out), .ext_mic_neg_ground_out(ext_mic_neg_ground_out),
        .capless_virtual_ground_sel_out(capless_virtual_ground_sel_out), .bias_code_out(bias_code_out),
        .outer_mic_supply_en_out(outer_mic_supply_en_out), .inner_mic_supply_en_out(inner_mic_supply_en_out),
        .button_series_out(button_series_out), .button_pressed_out(button_pressed_out),
        .monitor_feed_cut_out(monitor_feed_cut_out), .phone_line_in_gain_out(phone_line_in_gain_out),
        .phone_line_in_silence_out(phone_line_in_silence_out), .aux_l_level_out(aux_l_level_out),
        .aux_r_level_out(aux_r_level_out), .aux_l_boost_out(aux_l_boost_out), .aux_r_boost_out(aux_r_boost_out),
        .aux_l_mute_out(aux_l_mute_out), .aux_r_mute_out(aux_r_mute_out),
        .mixer_l_from_aux_out(mixer_l_from_aux_out), .mixer_r_from_aux_out(mixer_r_from_aux_out),
        .dac_l_level_out(dac_l_level_out), .dac_r_level_out(dac_r_level_out),
        .dac_boost_out(dac_boost_out), .dac_mute_out(dac_mute_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and a cycle ceiling so a stuck handshake cannot hang the run
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks: comparison, waiting and one AHB-Lite single transfer
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // Called just after an edge; ends one idle edge after the data phase
    task automatic ahb(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        hsel_in   <= 1'b1;
        haddr_in  <= {22'h0, idx, 2'h0};
        htrans_in <= AIM_HTRANS_NONSEQ;
        hwrite_in <= wr;
        hsize_in  <= 3'h2;
        @(posedge clk_in);
        while (hready_in !== 1'b1) @(posedge clk_in);
        hsel_in   <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= wd;
        @(posedge clk_in);
        while (hready_in !== 1'b1) @(posedge clk_in);
        rd = hrdata_out;
        chk("hresp", 32'h0, {31'h0, hresp_out});
        @(posedge clk_in);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] rd;
        ahb(1'b1, idx, wd, rd);
        cyc(3);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] rd;
        ahb(1'b0, idx, 32'h0, rd);
        chk($sformatf("read %h", idx), exp, rd);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {hsel_in, hwrite_in, agc_enable_in, dac_zero_cross_in, button_raw_in} = 5'h00;
        {haddr_in, hwdata_in} = 64'h0;
        htrans_in = 2'h0;
        hsize_in = 3'h2;
        fail_count = 0;
        comparisons = 0;
        cycles = 0;
        idx_tab = '{AIM_IDX_MIC_CFG, AIM_IDX_BIAS_CFG, AIM_IDX_MON_ATTEN, AIM_IDX_PHONE_IN,
                    AIM_IDX_AUX_L, AIM_IDX_AUX_R, AIM_IDX_DAC};
        msk_tab = '{AIM_MIC_MASK, AIM_BIAS_MASK, AIM_MON_MASK, AIM_PL_MASK,
                    AIM_FULL_MASK, AIM_FULL_MASK, AIM_FULL_MASK};
        rst_in = 1'b1;
        cyc(12);
        rst_in <= 1'b0;
        cyc(1);
        chk("reset outputs", 32'h1, {preamp_gain_code_out, preamp_mute_out, external_mic_select_out,
            bias_code_out, monitor_feed_cut_out, dac_mute_out, button_pressed_out, inner_mic_supply_en_out});
        // Reset values, then all ones and all zeros read back through the masks
        for (int i = 0; i < AIM_NUM_REGS; i++) rd_chk(idx_tab[i], {24'h0, AIM_REG_RESET});
        for (int i = 0; i < AIM_NUM_REGS; i++) begin
            wr(idx_tab[i], 32'hFFFF_FFFF);
            rd_chk(idx_tab[i], {24'h0, msk_tab[i]});
            wr(idx_tab[i], 32'h0);
            rd_chk(idx_tab[i], 32'h0);
        end
        // Unmapped place ignores the write and reads zero
        wr(8'h12, 32'hFF);
        rd_chk(8'h12, 32'h0);
        // Microphone: every bit on, then gain frozen while the AGC owns it
        wr(AIM_IDX_MIC_CFG, 32'h7F);
        chk("mic", 32'h3FE, {preamp_gain_code_out, preamp_mute_out, internal_mic_single_ended_out,
            external_mic_select_out, ext_mic_neg_ground_out, outer_mic_supply_en_out,
            inner_mic_supply_en_out});
        agc_enable_in <= 1'b1;
        wr(AIM_IDX_MIC_CFG, 32'h25);
        chk("mic agc", 32'h3D1, {preamp_gain_code_out, preamp_mute_out, internal_mic_single_ended_out,
            external_mic_select_out, ext_mic_neg_ground_out, outer_mic_supply_en_out,
            inner_mic_supply_en_out});
        agc_enable_in <= 1'b0;
        cyc(3);
        chk("mic gain", 32'h5, {28'h0, preamp_gain_code_out});
        // Bias, virtual ground and series button that follows the pin
        wr(AIM_IDX_BIAS_CFG, 32'h3D);
        chk("bias", 32'hD, {28'h0, capless_virtual_ground_sel_out, bias_code_out, button_series_out});
        button_raw_in <= 1'b1;
        cyc(5);
        chk("series press", 32'h1, {31'h0, button_pressed_out});
        button_raw_in <= 1'b0;
        cyc(5);
        chk("series release", 32'h0, {31'h0, button_pressed_out});
        // Parallel button: every debounce code, checked after its time, nonzero codes also just before
        for (int c = 0; c < 4; c++) begin
            ms = (c == 0) ? AIM_DBNC_MS_0 : (c == 1) ? AIM_DBNC_MS_1 : (c == 2) ? AIM_DBNC_MS_2 : AIM_DBNC_MS_3;
            wr(AIM_IDX_BIAS_CFG, {26'h0, c[1:0], 4'h0});
            chk("parallel type", 32'h0, {31'h0, button_series_out});
            button_raw_in <= 1'b1;
            if (ms > 0) begin
                cyc(ms * SCALE - 4);
                chk("debounce early", 32'h0, {31'h0, button_pressed_out});
                cyc(16);
            end else begin
                cyc(6);
            end
            chk("debounce press", 32'h1, {31'h0, button_pressed_out});
            button_raw_in <= 1'b0;
            cyc(ms * SCALE + 12);
            chk("debounce release", 32'h0, {31'h0, button_pressed_out});
        end
        // Monitor code above the top step passes as is
        wr(AIM_IDX_MON_ATTEN, 32'hFB);
        chk("monitor", 32'hB, {28'h0, monitor_feed_cut_out});
        // Phone-line gain and mute
        wr(AIM_IDX_PHONE_IN, 32'h3F);
        chk("phone on", 32'h3F, {26'h0, phone_line_in_gain_out, phone_line_in_silence_out});
        wr(AIM_IDX_PHONE_IN, 32'h15);
        chk("phone off", 32'h2A, {26'h0, phone_line_in_gain_out, phone_line_in_silence_out});
        // Auxiliary channels with opposite settings on each side
        wr(AIM_IDX_AUX_L, 32'hE5);
        wr(AIM_IDX_AUX_R, 32'h1A);
        chk("aux left", 32'h2F, {24'h0, aux_l_level_out, aux_l_boost_out, aux_l_mute_out,
            mixer_l_from_aux_out});
        chk("aux right", 32'hD0, {24'h0, aux_r_level_out, aux_r_boost_out, aux_r_mute_out,
            mixer_r_from_aux_out});
        // Playback levels borrowed from aux, then own with boost
        wr(AIM_IDX_DAC, 32'h23);
        chk("dac borrow", 32'h0BA, {22'h0, dac_l_level_out, dac_r_level_out});
        wr(AIM_IDX_DAC, 32'h43);
        chk("dac own", 32'h0C7, {21'h0, dac_l_level_out, dac_r_level_out, dac_boost_out});
        // Mute waits for a zero crossing; unmute is immediate
        wr(AIM_IDX_DAC, 32'h83);
        cyc(8);
        chk("dac mute early", 32'h0, {31'h0, dac_mute_out});
        dac_zero_cross_in <= 1'b1;
        cyc(1);
        dac_zero_cross_in <= 1'b0;
        cyc(6);
        chk("dac mute", 32'h1, {31'h0, dac_mute_out});
        wr(AIM_IDX_DAC, 32'h03);
        chk("dac unmute", 32'h0, {31'h0, dac_mute_out});
        end_sim();
    end
endmodule
